// ===== bench/bus_responder.sv
// Far-end bus model: paces accepts and reports write errors
`timescale 1ns/1ps
module bus_responder (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Behaviour select
    input wire logic slow,
    input wire logic err_on,
    input wire logic ce,
    // Bus
    input wire logic write_data_valid,
    output logic address_accept,
    output logic write_data_accept,
    output logic write_bus_error
);
    logic [15:0] rnd_r;

    // Stall pattern, runs of waits stay short
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rnd_r <= 16'hACE1;
        end else begin
            rnd_r <= {rnd_r[14:0],
                rnd_r[15] ^ rnd_r[13] ^ rnd_r[12] ^ rnd_r[10]};
        end
    end

    assign address_accept = !slow | rnd_r[0];
    assign write_data_accept = !slow | rnd_r[3];

    // error one clock late
    // Frozen edges accept nothing, so the error slot is held over them
    always_ff @(posedge clk) begin
        if (!nrst) begin
            write_bus_error <= 1'b0;
        end else if (ce) begin
            write_bus_error <= err_on & write_data_valid & write_data_accept;
        end
    end
endmodule : bus_responder

// ===== bench/testbench.sv
// Self-checking bench for the write buffer drain master
`timescale 1ns/1ps
module testbench;
    import burst_wr_pkg::*;
    logic clk, nrst, ce, wb_valid, slow, err_on;
    logic [31:0] wb_block_addr;
    logic [127:0] wb_data;
    logic [15:0] wb_be;
    logic wb_take, drain_done, drain_error, write_error_pulse;
    logic [33:0] bus_word_address;
    logic [3:0] byte_lane_enables;
    logic address_valid_flag, write_direction_flag, multi_beat_flag;
    logic first_beat_marker, last_beat_marker, address_accept;
    logic [31:0] write_data_bus, seed, pd;
    logic write_data_valid, write_data_accept, write_bus_error;
    logic hold_a, hold_d, prev_av;
    logic ce_jit;
    logic [31:0] ce_lf;
    logic [40:0] qa[$];
    logic [31:0] qd[$];
    logic [40:0] pa;
    wire logic [40:0] cur_a = {bus_word_address, byte_lane_enables,
        multi_beat_flag, first_beat_marker, last_beat_marker};
    int miscompares, n_tests, n_pulse;

    burst_write_bus_master dut (.clk(clk), .nrst(nrst), .ce(ce),
        .wb_valid(wb_valid), .wb_block_addr(wb_block_addr),
        .wb_data(wb_data), .wb_be(wb_be), .wb_take(wb_take),
        .drain_done(drain_done), .drain_error(drain_error),
        .write_error_pulse(write_error_pulse),
        .bus_word_address(bus_word_address),
        .byte_lane_enables(byte_lane_enables),
        .address_valid_flag(address_valid_flag),
        .write_direction_flag(write_direction_flag),
        .multi_beat_flag(multi_beat_flag),
        .first_beat_marker(first_beat_marker),
        .last_beat_marker(last_beat_marker),
        .address_accept(address_accept), .write_data_bus(write_data_bus),
        .write_data_valid(write_data_valid),
        .write_data_accept(write_data_accept),
        .write_bus_error(write_bus_error));

    bus_responder far (.clk(clk), .nrst(nrst), .slow(slow),
        .err_on(err_on), .ce(ce),
        .write_data_valid(write_data_valid),
        .address_accept(address_accept),
        .write_data_accept(write_data_accept),
        .write_bus_error(write_bus_error));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task final_report;
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Bus monitor, compares every accepted beat with the plan
    always @(posedge clk) begin
        if (!nrst) begin
            hold_a <= 1'b0;
            hold_d <= 1'b0;
            prev_av <= 1'b0;
        end else begin
            if (hold_a) check(cur_a === pa, "address moved in wait");
            if (hold_d) check(write_data_bus === pd, "data moved in wait");
            check(write_direction_flag === address_valid_flag &&
                (!multi_beat_flag || address_valid_flag), "flags");
            if (address_valid_flag && !prev_av)
                check(write_data_valid === 1'b1, "data late");
            if (address_valid_flag && address_accept && ce) begin
                check(qa.size() > 0 && cur_a === qa[0],
                    "address beat");
                if (qa.size() > 0) void'(qa.pop_front());
            end
            if (write_data_valid && write_data_accept && ce) begin
                check(qd.size() > 0 && write_data_bus === qd[0],
                    "data");
                if (qd.size() > 0) void'(qd.pop_front());
            end
            // A pulse frozen by clock enable is counted once
            if (write_error_pulse && ce) n_pulse++;
            hold_a <= address_valid_flag && !(address_accept && ce);
            hold_d <= write_data_valid && !(write_data_accept && ce);
            pa <= cur_a;
            pd <= write_data_bus;
            prev_av <= address_valid_flag;
        end
    end

    // One drain: plan the beats, request, wait for completion
    task automatic drain(input logic [15:0] be, input logic s,
        input logic e);
        logic [31:0] b;
        logic [127:0] d;
        logic full;
        int k, nb, n0;
        seed = lfsr(seed);
        b = seed;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            d[32*i +: 32] = seed;
        end
        full = (be === 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            if (full || be[4*i +: 4] != 4'h0) begin
                qa.push_back({b, i[1:0], be[4*i +: 4], full,
                    full && i == 0, full && i == 3});
                qd.push_back(d[32*i +: 32]);
            end
        end
        nb = qd.size();
        n0 = n_pulse;
        @(posedge clk);
        wb_valid <= 1'b1;
        wb_block_addr <= b;
        wb_data <= d;
        wb_be <= be;
        slow <= s;
        err_on <= e;
        @(negedge clk);
        check(wb_take === 1'b1, "request not taken");
        // Frozen edges take nothing, so hold the request through them
        @(posedge clk);
        while (ce !== 1'b1) @(posedge clk);
        wb_valid <= 1'b0;
        k = 0;
        while (drain_done !== 1'b1 && k < 500) begin
            @(negedge clk);
            k++;
        end
        check(k < 500, "drain hung");
        check(drain_error === (e && nb > 0), "drain error");
        check(qa.size() == 0 && qd.size() == 0, "beats missing");
        repeat (2) @(negedge clk);
        check(n_pulse - n0 == (e ? nb : 0), "error pulses");
    endtask : drain

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Clock enable jitter; high through reset so reset needs no enable
    always @(posedge clk) begin
        if (!nrst) begin
            ce <= 1'b1;
            ce_lf <= 32'h0000002D;
        end else begin
            ce_lf <= lfsr(ce_lf);
            ce <= !ce_jit || ce_lf[7] || ce_lf[9];
        end
    end

    // Watchdog, well beyond the longest expected run
    initial begin
        #200000;
        miscompares++;
        final_report;
    end

    // Corner cases first, then random drains
    initial begin
        nrst = 1'b0;
        ce_jit = 1'b0;
        wb_valid = 1'b0;
        wb_block_addr = 32'h00000000;
        wb_data = '0;
        wb_be = 16'h0000;
        slow = 1'b0;
        err_on = 1'b0;
        seed = 32'h0000002D;
        miscompares = 0;
        n_tests = 0;
        n_pulse = 0;
        repeat (10) @(posedge clk);
        check({address_valid_flag, write_data_valid} === 2'h0, "reset");
        nrst <= 1'b1;
        drain(16'hFFFF, 1'b0, 1'b0);
        drain(16'hFFFF, 1'b1, 1'b1);
        drain(16'h0000, 1'b0, 1'b0);
        drain(16'h00F0, 1'b1, 1'b0);
        drain(16'h7FFF, 1'b1, 1'b1);
        for (int i = 0; i < 60; i++) begin
            seed = lfsr(seed);
            ce_jit = seed[23];
            drain(seed[31] ? 16'hFFFF : seed[15:0], seed[20],
                seed[21] & seed[22]);
        end
        final_report;
    end
endmodule : testbench

// ===== design/beat_cursor.sv
// Walks the set bits of a beat mask in ascending order
`timescale 1ns/1ps
module beat_cursor
    import burst_wr_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Control
    input wire logic start,
    input wire logic [3:0] mask,
    input wire logic step,
    // State
    output logic [1:0] idx,
    output logic active,
    output logic last
);
    logic [3:0] mask_r;
    logic [1:0] idx_r;
    logic active_r;
    logic [1:0] first_idx;
    logic [1:0] next_idx;
    logic has_next;

    // Lowest set bit of the incoming mask, and next set bit above idx_r
    always_comb begin
        first_idx = IDX_RST;
        next_idx = idx_r;
        has_next = 1'b0;
        for (int i = BEATS - 1; i >= 0; i--) begin
            if (mask[i]) begin
                first_idx = 2'(i);
            end
            if (mask_r[i] && (2'(i) > idx_r)) begin
                next_idx = 2'(i);
                has_next = 1'b1;
            end
        end
    end

    // Mask capture
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mask_r <= 4'h0;
        end else if (ce && start) begin
            mask_r <= mask;
        end
    end

    // Position and activity; start wins over a stale step
    always_ff @(posedge clk) begin
        if (!nrst) begin
            idx_r <= IDX_RST;
            active_r <= 1'b0;
        end else if (ce) begin
            if (start) begin
                idx_r <= first_idx;
                active_r <= |mask;
            end else if (step && active_r) begin
                idx_r <= next_idx;
                active_r <= has_next;
            end
        end
    end

    assign idx = idx_r;
    assign active = active_r;
    assign last = active_r && !has_next;
endmodule : beat_cursor

// ===== design/burst_wr_pkg.sv
// Shared constants for the burst write bus master
package burst_wr_pkg;
    // Aligned block and beat geometry
    localparam int BLOCK_BYTES = 16;
    localparam int BEATS = 4;
    localparam int WORD_BYTES = 4;
    localparam int BEAT_IDX_W = 2;
    // Word address width (byte address bits 35:2)
    localparam int WORD_ADDR_W = 34;
    localparam int DATA_W = 32;
    // Word select value that every burst starts from
    localparam logic [1:0] BURST_START_SEL = 2'h0;
    // Word select value of the last beat in a burst
    localparam logic [1:0] BURST_END_SEL = 2'h3;
    // Byte enables carried by every burst beat
    localparam logic [3:0] FULL_WORD_BE = 4'hF;
    // Mask that visits all four beats
    localparam logic [3:0] ALL_BEATS_MASK = 4'hF;
    // Reset values
    localparam logic [1:0] IDX_RST = 2'h0;
endpackage : burst_wr_pkg

// ===== design/burst_write_bus_master.sv
// Write buffer drain master: one burst or a run of single writes
//
// How it works
// RQ1 - Burst only for full aligned 16-byte block
// RQ2 - Burst always starts at word select zero
// RQ3 - Hold address and enables until accepted
// RQ4 - Address valid high whenever burst address driven
// RQ5 - Write, burst, valid flags high with address
// RQ6 - First marker on first, last on final
// RQ7 - Hold data word until data accept seen
// RQ8 - Far end flags error one clock after accept
// RQ9 - Far end paces addresses with address accept
// RQ10 - First data word with its address
// RQ11 - Four beats, word select ascending zero-three
`timescale 1ns/1ps
module burst_write_bus_master
    import burst_wr_pkg::*;
#(
    parameter int ADDR_W = WORD_ADDR_W,
    parameter int DW = DATA_W
)
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // Write buffer side
    input wire logic wb_valid,
    input wire logic [ADDR_W-3:0] wb_block_addr,
    input wire logic [BEATS*DW-1:0] wb_data,
    input wire logic [BEATS*4-1:0] wb_be,
    output logic wb_take,
    output logic drain_done,
    output logic drain_error,
    output logic write_error_pulse,
    // Bus address path
    output logic [ADDR_W-1:0] bus_word_address,
    output logic [3:0] byte_lane_enables,
    output logic address_valid_flag,
    output logic write_direction_flag,
    output logic multi_beat_flag,
    output logic first_beat_marker,
    output logic last_beat_marker,
    input wire logic address_accept,
    // Bus write data path
    output logic [DW-1:0] write_data_bus,
    output logic write_data_valid,
    input wire logic write_data_accept,
    input wire logic write_bus_error
);
    logic busy_r;
    logic burst_r;
    logic [ADDR_W-3:0] base_r;
    logic [BEATS*DW-1:0] data_r;
    logic [BEATS*4-1:0] be_r;
    logic a_done_r;
    logic d_done_r;
    logic dacc_d_r;
    logic err_r;
    logic done_r;
    logic errp_r;
    logic [3:0] beat_mask;
    logic [1:0] a_idx;
    logic [1:0] d_idx;
    logic a_active;
    logic d_active;
    logic a_last;
    logic d_last;
    logic a_acc;
    logic d_acc;
    logic pair_step;
    logic a_step;
    logic d_step;
    logic start;
    logic finish;

    // Pick up a buffer only when idle
    assign start = wb_valid && !busy_r;
    assign wb_take = start;

    // Beat mask: full block means burst, otherwise words with any lane
    // RQ1 burst selection
    always_comb begin
        if (&wb_be) begin
            beat_mask = ALL_BEATS_MASK;
        end else begin
            for (int i = 0; i < BEATS; i++) begin
                beat_mask[i] = |wb_be[i*4 +: 4];
            end
        end
    end

    // Accept strobes; a frozen clock enable takes nothing
    assign a_acc = address_valid_flag && address_accept && ce;
    assign d_acc = write_data_valid && write_data_accept && ce;
    // Single writes move address and data together, so a word's data
    // never leads its address
    assign pair_step = (a_done_r || a_acc) && (d_done_r || d_acc);
    assign a_step = burst_r ? a_acc : pair_step;
    assign d_step = burst_r ? d_acc : pair_step;

    // Address and data beat cursors, both begin in the start cycle
    // RQ10 data with address
    // RQ2 RQ11 zero upward order
    beat_cursor u_addr_cur (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .start(start),
        .mask(beat_mask),
        .step(a_step),
        .idx(a_idx),
        .active(a_active),
        .last(a_last)
    );
    beat_cursor u_data_cur (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .start(start),
        .mask(beat_mask),
        .step(d_step),
        .idx(d_idx),
        .active(d_active),
        .last(d_last)
    );

    // Buffer capture and mode
    always_ff @(posedge clk) begin
        if (!nrst) begin
            burst_r <= 1'b0;
            base_r <= '0;
            data_r <= '0;
            be_r <= '0;
        end else if (ce && start) begin
            burst_r <= &wb_be;
            base_r <= wb_block_addr;
            data_r <= wb_data;
            be_r <= wb_be;
        end
    end

    // Per-word accept memory for single writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            a_done_r <= 1'b0;
            d_done_r <= 1'b0;
        end else if (ce) begin
            if (start || pair_step || burst_r) begin
                a_done_r <= 1'b0;
                d_done_r <= 1'b0;
            end else begin
                a_done_r <= a_done_r || a_acc;
                d_done_r <= d_done_r || d_acc;
            end
        end
    end

    // Drain ends once both paths are empty and the last error slot passed
    assign finish = busy_r && !a_active && !d_active && !dacc_d_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            busy_r <= 1'b0;
        end else if (ce) begin
            if (start) begin
                busy_r <= 1'b1;
            end else if (finish) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Error is only meaningful one clock after a data accept
    // RQ8 error sample slot
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dacc_d_r <= 1'b0;
            errp_r <= 1'b0;
            err_r <= 1'b0;
        end else if (ce) begin
            dacc_d_r <= d_acc;
            errp_r <= dacc_d_r && write_bus_error;
            if (start) begin
                err_r <= 1'b0;
            end else if (dacc_d_r && write_bus_error) begin
                err_r <= 1'b1;
            end
        end
    end

    // Completion report one clock after finish; error is the registered err_r, already set by the last error slot
    always_ff @(posedge clk) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= finish;
        end
    end
    assign drain_done = done_r;
    assign drain_error = err_r;
    assign write_error_pulse = errp_r;

    // Address path drive; held from cursor state until accepted
    // RQ3 address hold
    assign bus_word_address = {base_r, a_idx};
    assign byte_lane_enables = burst_r ? FULL_WORD_BE : be_r[a_idx*4 +: 4];
    // RQ4 valid while driven
    assign address_valid_flag = a_active && (burst_r || !a_done_r);
    // RQ5 control flags
    assign write_direction_flag = address_valid_flag;
    assign multi_beat_flag = address_valid_flag && burst_r;
    // RQ6 burst markers
    assign first_beat_marker = multi_beat_flag && (a_idx == BURST_START_SEL);
    assign last_beat_marker = multi_beat_flag && a_last;

    // Data path drive; word changes only when the cursor steps
    // RQ7 data hold
    assign write_data_bus = data_r[d_idx*DW +: DW];
    assign write_data_valid = d_active && (burst_r || !d_done_r);

    // Full buffer produces a burst, partial one does not
    // RQ1 check
    chk_burst_choice: assert property (@(posedge clk) // RQ1
        disable iff (!nrst)
        (start && ce) |=> (burst_r == $past(&wb_be)))
        else $error("burst chosen for wrong buffer contents");

    // RQ2 check
    chk_burst_start: assert property (@(posedge clk) // RQ2
        disable iff (!nrst)
        (start && ce && (&wb_be)) |=>
        (bus_word_address[1:0] == BURST_START_SEL))
        else $error("burst did not start at word zero");

    // RQ3 check
    chk_addr_hold: assert property (@(posedge clk) // RQ3
        disable iff (!nrst)
        (address_valid_flag && !(address_accept && ce)) |=>
        (address_valid_flag && $stable(bus_word_address)
        && $stable(byte_lane_enables)))
        else $error("address dropped before accept");

    // RQ4 check
    chk_burst_valid: assert property (@(posedge clk) // RQ4
        disable iff (!nrst)
        (a_acc && multi_beat_flag && !last_beat_marker) |=>
        address_valid_flag)
        else $error("gap in burst address valid");

    // RQ5 check
    chk_ctrl_flags: assert property (@(posedge clk) // RQ5
        disable iff (!nrst)
        (address_valid_flag && burst_r) |->
        (write_direction_flag && multi_beat_flag))
        else $error("control flags missing with burst address");

    // Sequences for the opening of a burst
    sequence burst_begin_s;
        start && ce && (&wb_be);
    endsequence
    sequence first_beat_s;
        first_beat_marker && address_valid_flag && !last_beat_marker;
    endsequence

    // RQ6 check
    chk_first_marker: assert property (@(posedge clk) // RQ6
        disable iff (!nrst)
        burst_begin_s |=> first_beat_s)
        else $error("first marker missing on first burst address");

    // RQ6 check
    chk_last_marker: assert property (@(posedge clk) // RQ6
        disable iff (!nrst)
        last_beat_marker |-> (a_idx == BURST_END_SEL))
        else $error("last marker on wrong beat");

    // RQ7 check
    chk_data_hold: assert property (@(posedge clk) // RQ7
        disable iff (!nrst)
        (write_data_valid && !(write_data_accept && ce)) |=>
        (write_data_valid && $stable(write_data_bus)))
        else $error("write data changed before accept");

    // RQ10 check
    chk_data_with_addr: assert property (@(posedge clk) // RQ10
        disable iff (!nrst)
        (start && ce) |=> ((write_data_valid == address_valid_flag)
        && (d_idx == a_idx)))
        else $error("first data word not with its address");

    // RQ11 check
    chk_beat_order: assert property (@(posedge clk) // RQ11
        disable iff (!nrst)
        (a_acc && multi_beat_flag && !last_beat_marker) |=>
        (a_idx == 2'($past(a_idx) + 2'h1)))
        else $error("burst word select not ascending");
endmodule : burst_write_bus_master
